// file: src/sewg_write_guard.sv
// Write-protection and power-on state of a serial-bus EEPROM
//
// Behaviour
// - Power-up clears the write enable latch
// - Only the set-latch command sets the latch
// - Completed array or status write clears latch
// - Write starts only on byte-aligned deselect
// - Array access ignored during internal write cycle
// - Power-up standby, chip select treated high
// - Serial output released unless driving read data
// - Active state entered only on select falling
// - Latch set only on deselect after opcode
// - Clear latch refuses array and status writes
// - Protect pin plus enable locks status bits
// - Block-protect bits guard chosen array region
`timescale 1ns/1ps
module sewg_write_guard #(
	parameter int WRITE_CYCLES = sewg_pkg::WRITE_CYCLES
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire sewg_pkg::sewg_pins_type pins,
	output logic                         soData,
	output logic                         soEnN,
	output logic                         linkActive,
	output logic                         writeInProgress,
	output logic                         writeEnableLatch,
	output logic                         hwProtectEnable,
	output logic                         blockProtectHigh,
	output logic                         blockProtectLow,
	output sewg_pkg::sewg_byte_type      byteOut,
	output logic                         byteStrobe,
	output logic                         commitArray,
	output logic                         commitStatus
);

	localparam int TW = $clog2(WRITE_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES - 1);

	typedef struct packed {
		sewg_pkg::sewg_link_type        link;
		logic                           prevCsN;
		logic                           prevSck;
		logic [7:0]                     shiftIn;
		logic [2:0]                     bitCnt;
		logic [2:0]                     byteCnt;
		logic [7:0]                     opcode;
		logic [sewg_pkg::ADDR_W-1:0]    addr;
		logic                           reading;
		logic [7:0]                     outShift;
		logic                           soBit;
		logic                           soEnN;
		logic                           write_enable_latch;
		logic                           hw_protect_enable;
		logic [1:0]                     bp;
		logic                           wip;
		logic [TW-1:0]                  timer;
		sewg_pkg::sewg_byte_type        byteOut;
		logic                           byteStrobe;
		logic                           commitArray;
		logic                           commitStatus;
		logic                           active;
	} sewg_state_type;

	sewg_state_type          q;
	sewg_state_type          next_q;
	sewg_pkg::sewg_pins_type pinS;
	logic                    csFall;
	logic                    csRise;
	logic                    sckRise;
	logic                    sckFall;
	logic                    hwLocked;
	logic [7:0]              shifted;
	logic [7:0]              statusByte;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; select resets high so power-up reads deselected

	sewg_sync #(
		.W       (4),
		.RST_VAL (4'h8)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d       (pins),
		.q       (pinS)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	function automatic logic blocked(input logic [sewg_pkg::ADDR_W-1:0] a,
	                                 input logic [1:0] bp);
		case (bp)
			2'h0:    blocked = 1'b0;
			2'h1:    blocked = (a >= sewg_pkg::QUARTER_BASE);
			2'h2:    blocked = (a >= sewg_pkg::HALF_BASE);
			default: blocked = 1'b1;
		endcase
	endfunction

	assign csFall   = q.prevCsN & ~pinS.csN;
	assign csRise   = ~q.prevCsN & pinS.csN;
	assign sckRise  = ~q.prevSck & pinS.sck;
	assign sckFall  = q.prevSck & ~pinS.sck;
	assign hwLocked = ~pinS.wpN & q.hw_protect_enable;
	assign shifted  = {q.shiftIn[6:0], pinS.si};

	always_comb begin
		statusByte                         = 8'h00;
		statusByte[sewg_pkg::SR_HW_PROTECT] = q.hw_protect_enable;
		statusByte[sewg_pkg::SR_BP_HIGH]   = q.bp[1];
		statusByte[sewg_pkg::SR_BP_LOW]    = q.bp[0];
		statusByte[sewg_pkg::SR_WEL]       = q.write_enable_latch;
		statusByte[sewg_pkg::SR_WIP]       = q.wip;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_q              = q;
		next_q.byteStrobe   = 1'b0;
		next_q.commitArray  = 1'b0;
		next_q.commitStatus = 1'b0;
		next_q.prevCsN      = pinS.csN;
		next_q.prevSck      = pinS.sck;
		if (q.wip) begin
			if (q.timer == '0) begin
				next_q.wip = 1'b0;
				next_q.write_enable_latch = 1'b0;
			end else begin
				next_q.timer = q.timer - TW'(1);
			end
		end
		case (q.link)
			sewg_pkg::LINK_STANDBY: begin
				next_q.soEnN   = 1'b1;
				next_q.reading = 1'b0;
				if (csFall) begin
					next_q.link    = sewg_pkg::LINK_ACTIVE;
					next_q.bitCnt  = 3'h0;
					next_q.byteCnt = 3'h0;
				end
			end
			sewg_pkg::LINK_ACTIVE: begin
				if (csRise) begin
					next_q.link    = sewg_pkg::LINK_STANDBY;
					next_q.soEnN   = 1'b1;
					next_q.reading = 1'b0;
					// Mid-byte deselect or busy device discards the frame
					if (q.bitCnt == 3'h0 && !q.wip) begin
						case (q.opcode)
							sewg_pkg::OP_SET_LATCH: begin
								if (q.byteCnt == sewg_pkg::BYTES_SHORT_CMD) begin
									next_q.write_enable_latch = 1'b1;
								end
							end
							sewg_pkg::OP_CLEAR_LATCH: begin
								if (q.byteCnt == sewg_pkg::BYTES_SHORT_CMD) begin
									next_q.write_enable_latch = 1'b0;
								end
							end
							sewg_pkg::OP_ARRAY_WRITE: begin
								// Page never straddles a protect boundary
								if (q.byteCnt > sewg_pkg::BYTES_ARRAY_HDR && q.write_enable_latch
								    && !blocked(q.addr, q.bp)) begin
									next_q.wip         = 1'b1;
									next_q.timer       = TIMER_LOAD;
									next_q.commitArray = 1'b1;
								end
							end
							sewg_pkg::OP_STATUS_WRITE: begin
								if (q.byteCnt == sewg_pkg::BYTES_STATUS_WR && q.write_enable_latch
								    && !hwLocked) begin
									next_q.hw_protect_enable         = q.shiftIn[sewg_pkg::SR_HW_PROTECT];
									next_q.bp           = {q.shiftIn[sewg_pkg::SR_BP_HIGH],
									                       q.shiftIn[sewg_pkg::SR_BP_LOW]};
									next_q.wip          = 1'b1;
									next_q.timer        = TIMER_LOAD;
									next_q.commitStatus = 1'b1;
								end
							end
							default: ;
						endcase
					end
				end else begin
					if (sckRise) begin
						next_q.shiftIn = shifted;
						next_q.bitCnt  = q.bitCnt + 3'h1;
						if (q.bitCnt == 3'h7) begin
							if (q.byteCnt != sewg_pkg::BYTES_SAT) begin
								next_q.byteCnt = q.byteCnt + 3'h1;
							end
							case (q.byteCnt)
								3'h0: begin
									next_q.opcode = shifted;
									// Status stays readable during a write cycle
									if (shifted == sewg_pkg::OP_STATUS_READ) begin
										next_q.reading  = 1'b1;
										next_q.outShift = statusByte;
									end
								end
								3'h1: next_q.addr[12:8] = shifted[4:0];
								3'h2: next_q.addr[7:0]  = shifted;
								default: begin
									if (q.opcode == sewg_pkg::OP_ARRAY_WRITE && q.write_enable_latch && !q.wip
									    && !blocked(q.addr, q.bp)) begin
										next_q.byteOut.addr = q.addr;
										next_q.byteOut.data = shifted;
										next_q.byteStrobe   = 1'b1;
										// Wrap inside the page
										next_q.addr[sewg_pkg::PAGE_BITS-1:0] =
											q.addr[sewg_pkg::PAGE_BITS-1:0] + 5'h1;
									end
								end
							endcase
						end
					end
					if (sckFall && q.reading) begin
						next_q.soBit    = q.outShift[7];
						next_q.outShift = {q.outShift[6:0], q.outShift[7]};
						next_q.soEnN    = 1'b0;
					end
				end
			end
			default: next_q.link = sewg_pkg::LINK_STANDBY;
		endcase
		// Own flop, so the linkActive output needs no state decode
		next_q.active = (next_q.link == sewg_pkg::LINK_ACTIVE);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q         <= '0;
			q.link    <= sewg_pkg::LINK_STANDBY;
			q.prevCsN <= 1'b1;
			q.soEnN   <= 1'b1;
			q.write_enable_latch     <= 1'b0;
			q.hw_protect_enable    <= sewg_pkg::RST_HW_PROTECT;
			q.bp      <= sewg_pkg::RST_BLOCK_PROT;
		end else begin
			q <= next_q;
		end
	end

	assign soData           = q.soBit;
	assign soEnN            = q.soEnN;
	assign linkActive       = q.active;
	assign writeInProgress  = q.wip;
	assign writeEnableLatch = q.write_enable_latch;
	assign hwProtectEnable  = q.hw_protect_enable;
	assign blockProtectHigh = q.bp[1];
	assign blockProtectLow  = q.bp[0];
	assign byteOut          = q.byteOut;
	assign byteStrobe       = q.byteStrobe;
	assign commitArray      = q.commitArray;
	assign commitStatus     = q.commitStatus;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_latch_set_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(q.write_enable_latch) |-> $past(csRise && q.opcode == sewg_pkg::OP_SET_LATCH
		                       && q.bitCnt == 3'h0 && q.byteCnt == sewg_pkg::BYTES_SHORT_CMD))
		else $error("latch set without a clean set-latch frame");

	a_latch_after_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(q.wip) |-> !q.write_enable_latch)
		else $error("latch still set after write cycle");

	a_write_needs_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(q.wip) |-> $past(q.write_enable_latch) && $past(csRise) && $past(q.bitCnt) == 3'h0)
		else $error("write cycle started without latch or aligned deselect");

	a_busy_no_array: assert property (@(posedge sys_clk) disable iff (!rst_n)
		q.byteStrobe |-> !$past(q.wip))
		else $error("array byte accepted during write cycle");

	a_status_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		q.commitStatus |-> !$past(hwLocked))
		else $error("status written while hardware locked");

	a_block_guard: assert property (@(posedge sys_clk) disable iff (!rst_n)
		q.commitArray |-> !$past(blocked(q.addr, q.bp)))
		else $error("write committed into protected block");

	a_output_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(q.link == sewg_pkg::LINK_STANDBY || !q.reading) |-> q.soEnN)
		else $error("serial output driven outside status read");

	a_busy_span: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(q.wip) |-> q.wip[*8])
		else $error("write cycle ended too early");

	a_active_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(q.link == sewg_pkg::LINK_ACTIVE) |-> $past(csFall))
		else $error("active state without select falling edge");

endmodule

// file: src/sewg_pkg.sv
// Shared constants and carrier types of the serial EEPROM write guard
package sewg_pkg;

	// Instruction opcodes, shifted in MSB first
	localparam logic [7:0]  OP_ARRAY_READ   = 8'h03;
	localparam logic [7:0]  OP_ARRAY_WRITE  = 8'h02;
	localparam logic [7:0]  OP_SET_LATCH    = 8'h06;
	localparam logic [7:0]  OP_CLEAR_LATCH  = 8'h04;
	localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
	localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;

	// Array geometry and protected region bases
	localparam int          ADDR_W          = 13;
	localparam int          PAGE_BITS       = 5;
	localparam logic [12:0] QUARTER_BASE    = 13'h1800;
	localparam logic [12:0] HALF_BASE       = 13'h1000;

	// Status byte field positions
	localparam int          SR_HW_PROTECT   = 7;
	localparam int          SR_BP_HIGH      = 3;
	localparam int          SR_BP_LOW       = 2;
	localparam int          SR_WEL          = 1;
	localparam int          SR_WIP          = 0;

	// Power-up values of the emulated non-volatile bits
	localparam logic        RST_HW_PROTECT  = 1'b0;
	localparam logic [1:0]  RST_BLOCK_PROT  = 2'h0;

	// Byte counts of the framed commands
	localparam logic [2:0]  BYTES_SHORT_CMD = 3'h1;
	localparam logic [2:0]  BYTES_STATUS_WR = 3'h2;
	localparam logic [2:0]  BYTES_ARRAY_HDR = 3'h3;
	localparam logic [2:0]  BYTES_SAT       = 3'h7;

	// Self-timed write cycle, longest time rounded down
	localparam int          WRITE_TIME_NS   = 5000000;
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          WRITE_CYCLES    = WRITE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		LINK_STANDBY = 2'b00,
		LINK_ACTIVE  = 2'b01
	} sewg_link_type;

	typedef struct packed {
		logic csN;
		logic sck;
		logic si;
		logic wpN;
	} sewg_pins_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} sewg_byte_type;

endpackage

// file: src/sewg_sync.sv
// Two-flop synchroniser for the asynchronous pins
`timescale 1ns/1ps
module sewg_sync #(
	parameter int              W       = 4,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sewg_sync_type;

	sewg_sync_type r;
	sewg_sync_type next_r;

	// First stage feeds only the second stage
	always_comb begin
		next_r.meta   = d;
		next_r.stable = r.meta;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= {RST_VAL, RST_VAL};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.stable;

endmodule

// file: dv/sewg_spi_host.sv
// Host SPI controller model driving the guard's serial pins
`timescale 1ns/1ps
module sewg_spi_host (
	input  wire logic sys_clk,
	input  wire logic soLine,
	output logic      csN,
	output logic      sck,
	output logic      si
);
	initial begin
		csN = 1'h1;
		sck = 1'h0;
		si  = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode 0 frame, MSB first; clock stands still outside frames
	task automatic frame(input int nBits, input logic [31:0] word, output logic [7:0] rx);
		rx = 8'h00;
		@(negedge sys_clk);
		csN = 1'h0;
		repeat (8) @(negedge sys_clk);
		for (int i = nBits - 1; i >= 0; i--) begin
			si = word[i];
			repeat (8) @(negedge sys_clk);
			sck = 1'h1;
			rx  = {rx[6:0], soLine};
			repeat (8) @(negedge sys_clk);
			sck = 1'h0;
		end
		repeat (8) @(negedge sys_clk);
		csN = 1'h1;
		// Released data line must not keep the last bit
		si = ~si;
		repeat (12) @(negedge sys_clk);
	endtask
endmodule

// file: dv/tb.sv
// Self-checking bench of the serial EEPROM write guard
`timescale 1ns/1ps
module tb;
	// Short write cycle, still long enough for a frame during it
	localparam int          WCYC            = 1000;
	localparam logic [12:0] ADDRS [4]       = '{13'h0FFF, 13'h1000, 13'h17FF, 13'h1800};
	localparam logic [13:0] LIMS [4]        = '{14'h2000, 14'h1800, 14'h1000, 14'h0000};
	logic                    sys_clk;
	logic                    rst_n;
	logic                    wpN;
	logic                    csN;
	logic                    sck;
	logic                    si;
	wire                     soLine;
	logic [7:0]              rx;
	int                      error_cnt       = 0;
	int                      samples_checked = 0;
	int                      arrCnt          = 0;
	int                      statCnt         = 0;
	int                      activeCnt       = 0;
	int                      strbCnt         = 0;
	sewg_pkg::sewg_pins_type pins;
	logic                    soData;
	logic                    soEnN;
	logic                    linkActive;
	logic                    writeInProgress;
	logic                    writeEnableLatch;
	logic                    hwProtectEnable;
	logic                    blockProtectHigh;
	logic                    blockProtectLow;
	sewg_pkg::sewg_byte_type byteOut;
	logic                    byteStrobe;
	logic                    commitArray;
	logic                    commitStatus;

	assign pins   = '{csN: csN, sck: sck, si: si, wpN: wpN};
	assign soLine = soEnN ? 1'hz : soData;

	sewg_write_guard #(.WRITE_CYCLES(WCYC)) dut_u (
		.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .soData(soData), .soEnN(soEnN),
		.linkActive(linkActive), .writeInProgress(writeInProgress),
		.writeEnableLatch(writeEnableLatch), .hwProtectEnable(hwProtectEnable),
		.blockProtectHigh(blockProtectHigh), .blockProtectLow(blockProtectLow),
		.byteOut(byteOut), .byteStrobe(byteStrobe), .commitArray(commitArray),
		.commitStatus(commitStatus)
	);

	sewg_spi_host host_u (
		.sys_clk(sys_clk), .soLine(soLine), .csN(csN), .sck(sck), .si(si)
	);

	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (commitArray === 1'h1) arrCnt++;
		if (commitStatus === 1'h1) statCnt++;
		if (linkActive === 1'h1) activeCnt++;
		if (byteStrobe === 1'h1) strbCnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic op(input int nBits, input logic [31:0] word);
		host_u.frame(nBits, word, rx);
	endtask

	task automatic set_latch();
		op(8, {24'h0, sewg_pkg::OP_SET_LATCH});
		check(writeEnableLatch, 1);
	endtask

	// Bounded wait for the self-timed cycle to end
	task automatic wait_idle();
		int n;
		n = 0;
		while (writeInProgress !== 1'h0 && n < WCYC + 200) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == WCYC + 200) begin
			error_cnt++;
			$display("wrong value at %0t: write cycle hung", $time);
			give_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		int m;
		rst_n = 1'h0;
		wpN   = 1'h1;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk) rst_n = 1'h1;
		repeat (16) @(negedge sys_clk);
		check(soEnN, 1);
		check({linkActive, activeCnt[0]}, 0);
		check(writeEnableLatch, 0);
		check({hwProtectEnable, blockProtectHigh, blockProtectLow, writeInProgress}, 0);
		op(32, {sewg_pkg::OP_ARRAY_WRITE, 16'h0000, 8'hA5});
		check(activeCnt > 0, 1);
		check(arrCnt, 0);
		check(strbCnt, 0);
		op(16, {sewg_pkg::OP_STATUS_WRITE, 8'h0C});
		check(statCnt, 0);
		op(7, {25'h0, sewg_pkg::OP_SET_LATCH[7:1]});
		check(writeEnableLatch, 0);
		// Set-latch and write in one frame: no deselect, so nothing happens
		op(32, {sewg_pkg::OP_SET_LATCH, sewg_pkg::OP_ARRAY_WRITE, 16'h0020});
		check({writeEnableLatch, arrCnt[0]}, 0);
		set_latch();
		op(8, {24'h0, sewg_pkg::OP_CLEAR_LATCH});
		check(writeEnableLatch, 0);
		set_latch();
		op(16, {sewg_pkg::OP_STATUS_READ, 8'h00});
		check(rx, 8'h02);
		check(soEnN, 1);
		// Mid-byte deselect must be thrown away
		op(31, {sewg_pkg::OP_ARRAY_WRITE, 16'h0010, 8'h5A} >> 1);
		check(arrCnt, 0);
		check(strbCnt, 0);
		op(32, {sewg_pkg::OP_ARRAY_WRITE, 16'h0010, 8'h5A});
		check(arrCnt, 1);
		check(strbCnt, 1);
		check(writeInProgress, 1);
		check({byteOut.addr, byteOut.data}, {13'h0010, 8'h5A});
		op(8, {24'h0, sewg_pkg::OP_CLEAR_LATCH});
		check(writeEnableLatch, 1);
		op(32, {sewg_pkg::OP_ARRAY_WRITE, 16'h0100, 8'h11});
		check({arrCnt[3:0], writeInProgress}, {4'h1, 1'h1});
		check(strbCnt, 1);
		wait_idle();
		check(writeEnableLatch, 0);
		for (int b = 0; b < 4; b++) begin
			set_latch();
			op(16, {sewg_pkg::OP_STATUS_WRITE, 4'h0, b[1:0], 2'h0});
			wait_idle();
			check({blockProtectHigh, blockProtectLow}, b);
			check(writeEnableLatch, 0);
			for (int k = 0; k < 4; k++) begin
				set_latch();
				n = arrCnt;
				m = strbCnt;
				op(32, {sewg_pkg::OP_ARRAY_WRITE, 3'h0, ADDRS[k], 8'h3C});
				check(arrCnt - n, {1'h0, ADDRS[k]} < LIMS[b]);
				check(strbCnt - m, {1'h0, ADDRS[k]} < LIMS[b]);
				wait_idle();
			end
		end
		set_latch();
		op(16, {sewg_pkg::OP_STATUS_WRITE, 8'h80});
		wait_idle();
		check({hwProtectEnable, blockProtectHigh}, 2'h2);
		wpN = 1'h0;
		set_latch();
		n = statCnt;
		op(16, {sewg_pkg::OP_STATUS_WRITE, 8'h0C});
		check(statCnt - n, 0);
		check(blockProtectLow, 0);
		wpN = 1'h1;
		set_latch();
		op(16, {sewg_pkg::OP_STATUS_WRITE, 8'h00});
		check(statCnt - n, 1);
		wait_idle();
		check(hwProtectEnable, 0);
		give_verdict();
	end
endmodule
